// ---- logic/acqs_sched_top.sv ----
// acquisition scheduler with sampling, calculation, logging and power
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "acqs_map.svh"
module acqs_sched_top
  import acqs_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = `ACQS_CLK_HZ / 1000 * `ACQS_TB_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  // interrupt
  output logic irq,
  // sample, calculation and log strobes
  output logic [3:0] sample_analog,
  output logic sample_multivariable_transducer,
  output logic sample_resistance_temperature_sensor,
  output logic [2:0] sample_pulse,
  output logic calc_strobe,
  output logic log_strobe,
  // power switches
  output logic xdcr_power,
  output logic [3:0] tx_analog_power,
  output logic [2:0] tx_pulse_power
);
  // ----------------------------------------------------------------
  // configuration and status state
  // ----------------------------------------------------------------
  acqs_per_t log_per, calc_per, samp_per;
  logic [5:0] in_en;
  logic pulse3_en;
  logic xdcr_warm_mode;
  acqs_warm_t xdcr_warm, tx_warm;
  logic tx_en;
  acqs_pwr_t an_set [4];
  logic [2:0] pulse_set;
  logic [2:0] irq_stat, irq_mask;
  logic incompat, invalid, invalid_q;
  acqs_per_t samp_run, calc_run, samples_per_calc, calcs_per_log;
  logic [23:0] tb_cnt;
  logic base_tick, log_tick, calc_tick, samp_tick, pulse_tick;
  logic reject;

  function automatic logic per_ok(input logic [31:0] v,
                                  input acqs_per_t lo);
    per_ok = (v[31:19] == 13'h0000) && (v[18:0] >= lo) &&
             (v[18:0] <= `ACQS_PER_MAX);
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_log, wr_calc, wr_samp, wr_xdcr, wr_txw;
  logic ok_log, ok_calc, ok_samp, ok_xw, ok_tw;
  assign wr_log = wr_stb && (addr == `ACQS_A_LOG);
  assign wr_calc = wr_stb && (addr == `ACQS_A_CALC);
  assign wr_samp = wr_stb && (addr == `ACQS_A_SAMP);
  assign wr_xdcr = wr_stb && (addr == `ACQS_A_XDCR);
  assign wr_txw = wr_stb && (addr == `ACQS_A_TXW);
  // a log interval shorter than the calc period cannot hold it
  assign ok_log = per_ok(wr_data, `ACQS_PER_1S) &&
                  (wr_data[18:0] >= calc_per);
  assign ok_calc = per_ok(wr_data, `ACQS_PER_1S) &&
                   (wr_data[18:0] <= log_per);
  assign ok_samp = per_ok(wr_data, `ACQS_PER_MIN);
  // the excitation mode bit sits above the warm field, so only the gap
  // between them must be clear; the shared warm word has no mode bit
  assign ok_xw = (wr_data[15:13] == 3'h0) &&
                 (wr_data[12:0] >= `ACQS_WARM_MIN) &&
                 (wr_data[12:0] <= `ACQS_WARM_MAX);
  assign ok_tw = ok_xw && (wr_data[31:16] == 16'h0000);
  // out-of-range writes keep the old value and raise an event
  assign reject = (wr_log && !ok_log) || (wr_calc && !ok_calc) ||
                  (wr_samp && !ok_samp) || (wr_xdcr && !ok_xw) ||
                  (wr_txw && !ok_tw);

  // period registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      log_per <= `ACQS_LOG_RST;
      calc_per <= `ACQS_CALC_RST;
      samp_per <= `ACQS_SAMP_RST;
    end else begin
      if (wr_log && ok_log) log_per <= wr_data[18:0];
      if (wr_calc && ok_calc) calc_per <= wr_data[18:0];
      if (wr_samp && ok_samp) samp_per <= wr_data[18:0];
    end
  end

  // input enables; pulse 1 and 2 have no storage at all
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_en <= 6'h00;
      pulse3_en <= 1'b0;
    end else if (wr_stb && (addr == `ACQS_A_INEN)) begin
      in_en <= wr_data[5:0];
      pulse3_en <= wr_data[`ACQS_INEN_P3_BIT];
    end
  end

  // transducer excitation: bit clear is always on, set is warm-up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      xdcr_warm_mode <= 1'b0;
      xdcr_warm <= `ACQS_WARM_RST;
    end else if (wr_xdcr && ok_xw) begin
      xdcr_warm_mode <= wr_data[`ACQS_XDCR_MODE_BIT];
      xdcr_warm <= wr_data[12:0];
    end
  end

  // transmitter settings are forced off while the mode is disabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_en <= 1'b0;
      pulse_set <= 3'h0;
      for (int i = 0; i < 4; i++) an_set[i] <= ACQS_PWR_OFF;
    end else if (wr_stb && (addr == `ACQS_A_TXC)) begin
      tx_en <= wr_data[`ACQS_TX_EN_BIT];
      pulse_set <= wr_data[`ACQS_TX_EN_BIT] ?
                   wr_data[`ACQS_PSET_LSB +: 3] : 3'h0;
      for (int i = 0; i < 4; i++) begin
        an_set[i] <= wr_data[`ACQS_TX_EN_BIT] ?
                     acqs_pwr_t'(wr_data[2*i +: 2]) : ACQS_PWR_OFF;
      end
    end else if (!tx_en) begin
      pulse_set <= 3'h0;
      for (int i = 0; i < 4; i++) an_set[i] <= ACQS_PWR_OFF;
    end
  end

  // shared analog transmitter warm-up time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_warm <= `ACQS_WARM_RST;
    end else if (wr_txw && ok_tw) begin
      tx_warm <= wr_data[12:0];
    end
  end

  // ----------------------------------------------------------------
  // 0.1 s timebase and period dividers
  // ----------------------------------------------------------------
  assign base_tick = (tb_cnt == 24'(BASE_CYCLES - 1));

  // one prescaler feeds every divider so all ticks share edges
  always_ff @(posedge core_clk) begin
    if (rst || base_tick) begin
      tb_cnt <= 24'h000000;
    end else begin
      tb_cnt <= tb_cnt + 24'h000001;
    end
  end

  acqs_div_if l_if();
  acqs_div_if c_if();
  acqs_div_if s_if();
  acqs_div_if p_if();

  // a log tick restarts calc, a calc tick restarts sampling
  assign log_tick = l_if.tick;
  assign calc_tick = c_if.tick || log_tick;
  assign samp_tick = s_if.tick || calc_tick;
  assign pulse_tick = p_if.tick;

  assign l_if.base_tick = base_tick;
  assign l_if.period = log_per;
  assign l_if.restart = 1'b0;
  assign c_if.base_tick = base_tick;
  assign c_if.period = calc_per;
  assign c_if.restart = log_tick;
  assign s_if.base_tick = base_tick;
  assign s_if.period = samp_per;
  assign s_if.restart = calc_tick;
  assign p_if.base_tick = base_tick;
  assign p_if.period = `ACQS_PULSE_PER;
  assign p_if.restart = 1'b0;

  acqs_period_div u_log_div (.core_clk(core_clk), .rst(rst), .d(l_if));
  acqs_period_div u_calc_div (.core_clk(core_clk), .rst(rst), .d(c_if));
  acqs_period_div u_samp_div (.core_clk(core_clk), .rst(rst), .d(s_if));
  acqs_period_div u_pulse_div (.core_clk(core_clk), .rst(rst), .d(p_if));

  // ----------------------------------------------------------------
  // strobes, counts and configuration checks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_analog <= 4'h0;
      sample_multivariable_transducer <= 1'b0;
      sample_resistance_temperature_sensor <= 1'b0;
      sample_pulse <= 3'h0;
      calc_strobe <= 1'b0;
      log_strobe <= 1'b0;
    end else begin
      sample_analog <= {4{samp_tick}} & in_en[3:0];
      sample_multivariable_transducer <= samp_tick && in_en[4];
      sample_resistance_temperature_sensor <= samp_tick && in_en[5];
      sample_pulse <= {3{pulse_tick}} & {pulse3_en, 2'b11};
      calc_strobe <= calc_tick;
      log_strobe <= log_tick;
    end
  end

  // counts are measured over each completed period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      samp_run <= 19'h00000;
      samples_per_calc <= 19'h00000;
    end else if (calc_tick) begin
      samples_per_calc <= samp_run + 19'h00001;
      samp_run <= 19'h00000;
    end else if (samp_tick) begin
      samp_run <= samp_run + 19'h00001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      calc_run <= 19'h00000;
      calcs_per_log <= 19'h00000;
    end else if (log_tick) begin
      calcs_per_log <= calc_run + 19'h00001;
      calc_run <= 19'h00000;
    end else if (calc_tick) begin
      calc_run <= calc_run + 19'h00001;
    end
  end

  assign invalid = (samp_per > calc_per);

  // a log tick that cuts a calc period short marks a misfit pair
  always_ff @(posedge core_clk) begin
    if (rst) begin
      incompat <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      invalid_q <= invalid;
      if (log_tick && !c_if.tick) begin
        incompat <= 1'b1;
      end else if ((wr_log && ok_log) || (wr_calc && ok_calc)) begin
        incompat <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // power control
  // ----------------------------------------------------------------
  logic [3:0] an_pwr;
  acqs_warmup u_xdcr_pwr (
    .core_clk(core_clk), .rst(rst),
    .mode(xdcr_warm_mode ? ACQS_PWR_WARM : ACQS_PWR_ON),
    .gate(in_en[4] || in_en[5]), .warm(xdcr_warm),
    .period(samp_per), .remain(s_if.remain), .power(xdcr_power));

  // one gate per analog transmitter
  generate
    for (genvar g = 0; g < 4; g++) begin : g_an
      acqs_warmup u_an_pwr (
        .core_clk(core_clk), .rst(rst), .mode(an_set[g]),
        .gate(tx_en), .warm(tx_warm), .period(samp_per),
        .remain(s_if.remain), .power(an_pwr[g]));
    end
  endgenerate
  assign tx_analog_power = an_pwr;

  // pulse transmitters have no warm-up; the setting is just on or off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_pulse_power <= 3'h0;
    end else begin
      tx_pulse_power <= {3{tx_en}} & pulse_set;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  logic [2:0] irq_set;
  assign irq_set = {reject || incompat_evt(log_tick, c_if.tick) ||
                    (invalid && !invalid_q), calc_tick, log_tick};

  function automatic logic incompat_evt(input logic lt, input logic ct);
    incompat_evt = lt && !ct;
  endfunction

  // set wins over a clear written in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_stb && (addr == `ACQS_A_IMASK)) irq_mask <= wr_data[2:0];
      if (wr_stb && (addr == `ACQS_A_ISTAT)) begin
        irq_stat <= (irq_stat & ~wr_data[2:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  logic [31:0] next_rd;
  always_comb begin
    next_rd = 32'h00000000;
    unique case (addr)
      `ACQS_A_LOG: next_rd = {13'h0000, log_per};
      `ACQS_A_CALC: next_rd = {13'h0000, calc_per};
      `ACQS_A_SAMP: next_rd = {13'h0000, samp_per};
      `ACQS_A_INEN: next_rd = {23'h000000, pulse3_en, 2'b11, in_en};
      `ACQS_A_XDCR: next_rd = {15'h0000, xdcr_warm_mode, 3'h0, xdcr_warm};
      `ACQS_A_TXC: next_rd = {15'h0000, tx_en, 5'h00, pulse_set,
                              an_set[3], an_set[2], an_set[1], an_set[0]};
      `ACQS_A_TXW: next_rd = {19'h00000, tx_warm};
      `ACQS_A_STAT: next_rd = {30'h00000000, incompat, invalid};
      `ACQS_A_SPC: next_rd = {13'h0000, samples_per_calc};
      `ACQS_A_CPL: next_rd = {13'h0000, calcs_per_log};
      `ACQS_A_ISTAT: next_rd = {29'h00000000, irq_stat};
      `ACQS_A_IMASK: next_rd = {29'h00000000, irq_mask};
      `ACQS_A_PWR: next_rd = {24'h000000, tx_pulse_power,
                              tx_analog_power, xdcr_power};
      default: next_rd = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= rd_stb ? next_rd : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  log_nests_calc_a: assert property (log_strobe |-> calc_strobe)
    else $error("log strobe without calc strobe");
  calc_nests_samp_a: assert property (calc_tick |-> samp_tick)
    else $error("calc tick without sample tick");
  pulse_fixed_en_a: assert property (
    pulse_tick |=> (sample_pulse[1:0] == 2'b11))
    else $error("pulse 1 or 2 not sampled");
  pulse_on_base_a: assert property (pulse_tick |-> base_tick)
    else $error("pulse sample off the timebase");
  disabled_quiet_a: assert property (
    !in_en[0] |=> !sample_analog[0])
    else $error("disabled analog input sampled");
  tx_off_all_a: assert property (
    !tx_en ##1 !tx_en |=> (tx_pulse_power == 3'h0) &&
    (tx_analog_power == 4'h0))
    else $error("transmitter power with mode disabled");
  invalid_flag_a: assert property (
    rd_stb && (addr == `ACQS_A_STAT) && (samp_per > calc_per)
    |=> rd_data[0])
    else $error("invalid configuration not flagged");
  xdcr_on_a: assert property (
    !xdcr_warm_mode && in_en[4] ##1 !xdcr_warm_mode && in_en[4]
    |=> xdcr_power)
    else $error("always-on transducer unpowered");
  warm_long_on_a: assert property (
    xdcr_warm_mode && in_en[4] && ({6'h00, xdcr_warm} >= samp_per)
    ##1 $stable(xdcr_warm_mode) && $stable(xdcr_warm) &&
    $stable(samp_per) && in_en[4] |=> xdcr_power)
    else $error("long warm-up did not hold power");
  warm_gap_off_a: assert property (
    xdcr_warm_mode && ({6'h00, xdcr_warm} < samp_per) &&
    (s_if.remain >= {6'h00, xdcr_warm}) |=> !xdcr_power)
    else $error("transducer powered outside warm-up");

  log_seen_c: cover property (log_strobe);
  misfit_seen_c: cover property (incompat);
  warm_drop_c: cover property (xdcr_warm_mode ##1 $fell(xdcr_power));
  reject_seen_c: cover property (reject);
endmodule

// ---- logic/acqs_map.svh ----
// register offsets, reset values and timing constants of the scheduler
`ifndef ACQS_MAP_SVH
`define ACQS_MAP_SVH

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define ACQS_CLK_HZ 125000000
`define ACQS_TB_MS 100
`define ACQS_PULSE_PER 19'h0000A

// ----------------------------------------------------------------
// period limits and reset values, in 0.1 s ticks
// ----------------------------------------------------------------
`define ACQS_PER_MAX 19'h69780
`define ACQS_PER_1S 19'h0000A
`define ACQS_PER_MIN 19'h00001
`define ACQS_LOG_RST 19'h08CA0
`define ACQS_CALC_RST 19'h00258
`define ACQS_SAMP_RST 19'h0000A
`define ACQS_WARM_MIN 13'h0001
`define ACQS_WARM_MAX 13'h1770
`define ACQS_WARM_RST 13'h000A

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ACQS_A_LOG 8'h00
`define ACQS_A_CALC 8'h04
`define ACQS_A_SAMP 8'h08
`define ACQS_A_INEN 8'h0C
`define ACQS_A_XDCR 8'h10
`define ACQS_A_TXC 8'h14
`define ACQS_A_TXW 8'h18
`define ACQS_A_STAT 8'h1C
`define ACQS_A_SPC 8'h20
`define ACQS_A_CPL 8'h24
`define ACQS_A_ISTAT 8'h28
`define ACQS_A_IMASK 8'h2C
`define ACQS_A_PWR 8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACQS_XDCR_MODE_BIT 16
`define ACQS_TX_EN_BIT 16
`define ACQS_PSET_LSB 8
`define ACQS_INEN_P3_BIT 8

`endif

// ---- logic/acqs_pkg.sv ----
// types shared by the acquisition scheduler modules
package acqs_pkg;
  // per-input power setting; 2'b11 is not a legal code
  typedef enum logic [1:0] {
    ACQS_PWR_OFF = 2'b00,
    ACQS_PWR_ON = 2'b01,
    ACQS_PWR_WARM = 2'b10
  } acqs_pwr_t;

  typedef logic [18:0] acqs_per_t;
  typedef logic [12:0] acqs_warm_t;
endpackage

// ---- logic/acqs_div_if.sv ----
// link between the scheduler core and one period divider
`timescale 1ns/1ps
interface acqs_div_if;
  logic base_tick;
  logic [18:0] period;
  logic restart;
  logic tick;
  logic [18:0] remain;
  modport ctl(output base_tick, output period, output restart,
              input tick, input remain);
  modport div(input base_tick, input period, input restart,
              output tick, output remain);
endinterface

// ---- logic/acqs_period_div.sv ----
// period divider counting 0.1 s ticks, with restart for alignment
`timescale 1ns/1ps
`include "acqs_map.svh"
module acqs_period_div
  import acqs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control side
  acqs_div_if.div d
);
  logic [18:0] cnt;
  logic [18:0] last;

  // last count of the period; period is never below one tick
  assign last = d.period - `ACQS_PER_MIN;
  assign d.tick = d.base_tick && (cnt >= last);
  assign d.remain = (cnt >= last) ? 19'h00000 : last - cnt;

  // restart only comes on a base tick, so alignment is exact
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 19'h00000;
    end else if (d.base_tick) begin
      if (d.restart || d.tick) begin
        cnt <= 19'h00000;
      end else begin
        cnt <= cnt + 19'h00001;
      end
    end
  end
endmodule

// ---- logic/acqs_warmup.sv ----
// power gate for one transducer or transmitter with warm-up timing
`timescale 1ns/1ps
module acqs_warmup
  import acqs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // setting
  input wire acqs_pwr_t mode,
  input wire logic gate,
  input wire logic [12:0] warm,
  // sampling schedule
  input wire logic [18:0] period,
  input wire logic [18:0] remain,
  // power switch
  output logic power
);
  logic next_power;
  logic [18:0] warm_w;

  assign warm_w = {6'h00, warm};

  // power ahead of the next sample for the warm-up window
  always_comb begin
    next_power = 1'b0;
    unique case (mode)
      ACQS_PWR_ON: next_power = gate;
      ACQS_PWR_WARM: begin
        // warm-up not shorter than the period behaves as always on
        if (warm_w >= period) begin
          next_power = gate;
        end else begin
          next_power = gate && (remain < warm_w);
        end
      end
      ACQS_PWR_OFF: next_power = 1'b0;
      default: next_power = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power <= 1'b0;
    end else begin
      power <= next_power;
    end
  end
endmodule

// ---- test/acqs_sensor_model.sv ----
// sensors and transmitters fed and sampled by the scheduler
`timescale 1ns/1ps
module acqs_sensor_model #(
  parameter int unsigned PULSE_GAP = 40
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // strobes
  input wire logic [3:0] sample_analog,
  input wire logic sample_multivariable_transducer,
  input wire logic [2:0] sample_pulse,
  input wire logic calc_strobe,
  input wire logic log_strobe,
  // power feed
  input wire logic xdcr_power
);
  int a0_cnt = 0;
  int a1_cnt = 0;
  int p1_cnt = 0;
  int p3_cnt = 0;
  int unpowered = 0;
  int off_cycles = 0;
  int nest_err = 0;
  int gap_err = 0;
  int gap = 0;
  logic seen = 1'b0;
  // count samples of analog 0 and 1 and pulse 1 and 3; a transducer read unpowered is a fault
  always @(posedge core_clk) begin
    a0_cnt <= a0_cnt + int'(sample_analog[0]);
    a1_cnt <= a1_cnt + int'(sample_analog[1]);
    p1_cnt <= p1_cnt + int'(sample_pulse[0]);
    p3_cnt <= p3_cnt + int'(sample_pulse[2]);
    if (sample_multivariable_transducer && xdcr_power !== 1'b1) begin
      unpowered <= unpowered + 1;
    end
    if (a0_cnt > 0 && xdcr_power === 1'b0) begin
      off_cycles <= off_cycles + 1;
    end
    // a log strobe without calc, or calc without sample, breaks nesting
    if ((log_strobe && !calc_strobe) ||
        (a0_cnt > 0 && calc_strobe && !sample_analog[0])) begin
      nest_err <= nest_err + 1;
    end
  end
  // pulse spacing is fixed whatever the sampling period; first gap unknown
  always @(posedge core_clk) begin
    if (rst) begin
      seen <= 1'b0;
      gap <= 0;
    end else if (sample_pulse[0]) begin
      if (seen && gap + 1 != PULSE_GAP) begin
        gap_err <= gap_err + 1;
      end
      seen <= 1'b1;
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
endmodule

// ---- test/tb_acqs_sched_top.sv ----
// self-checking bench for the acquisition scheduler
`timescale 1ns/1ps
`include "acqs_map.svh"
module tb_acqs_sched_top;
  import acqs_pkg::*;
  // a short timebase keeps log periods within the run
  localparam int unsigned BASE = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data, v;
  logic irq, calc_strobe, log_strobe, xdcr_power, smvt, srtd;
  logic [3:0] sample_analog, tx_analog_power;
  logic [2:0] sample_pulse, tx_pulse_power;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int rtd_cnt = 0;
  int n;
  acqs_sched_top #(.BASE_CYCLES(BASE)) u_acqs_sched_top (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq),
    .sample_analog(sample_analog), .sample_multivariable_transducer(smvt),
    .sample_resistance_temperature_sensor(srtd),
    .sample_pulse(sample_pulse), .calc_strobe(calc_strobe),
    .log_strobe(log_strobe), .xdcr_power(xdcr_power),
    .tx_analog_power(tx_analog_power), .tx_pulse_power(tx_pulse_power));
  acqs_sensor_model #(.PULSE_GAP(10 * BASE)) u_acqs_sensor_model (
    .core_clk(core_clk), .rst(rst), .sample_analog(sample_analog),
    .sample_multivariable_transducer(smvt), .sample_pulse(sample_pulse),
    .calc_strobe(calc_strobe), .log_strobe(log_strobe),
    .xdcr_power(xdcr_power));
  // 125 MHz clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    // step past the edge so callers see the updated state
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, well above the fewer than a thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    rtd_cnt += int'(srtd);
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH %0t run did not finish", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rc(`ACQS_A_LOG, 32'h00008CA0);
    rc(`ACQS_A_CALC, 32'h00000258);
    rc(`ACQS_A_SAMP, 32'h0000000A);
    rc(`ACQS_A_INEN, 32'h000000C0);
    rc(8'h3C, 32'h00000000);
    // out of range writes keep the old value and raise the error event
    wr(`ACQS_A_IMASK, 32'h00000004);
    wr(`ACQS_A_CALC, 32'h00000009);
    rc(`ACQS_A_CALC, 32'h00000258);
    chk({31'h0, irq}, 32'h1);
    wr(`ACQS_A_ISTAT, 32'h00000004);
    chk({31'h0, irq}, 32'h0);
    wr(`ACQS_A_LOG, 32'h00069781);
    rc(`ACQS_A_LOG, 32'h00008CA0);
    // short periods: calc 1 s, log 2 s, sample 0.5 s
    wr(`ACQS_A_CALC, 32'h0000000A);
    wr(`ACQS_A_LOG, 32'h00000014);
    wr(`ACQS_A_SAMP, 32'h00000005);
    rc(`ACQS_A_LOG, 32'h00000014);
    wr(`ACQS_A_CALC, 32'h00000015);
    rc(`ACQS_A_CALC, 32'h0000000A);
    idle(90);
    chk(u_acqs_sensor_model.p3_cnt, 32'h0);
    chk(u_acqs_sensor_model.p1_cnt > 0, 32'h1);
    wr(`ACQS_A_INEN, 32'h00000111);
    rc(`ACQS_A_INEN, 32'h000001D1);
    // sampling slower than calculation is flagged
    wr(`ACQS_A_SAMP, 32'h00000014);
    rd(`ACQS_A_STAT, v);
    chk(v & 32'h1, 32'h1);
    wr(`ACQS_A_SAMP, 32'h00000005);
    rd(`ACQS_A_STAT, v);
    chk(v & 32'h1, 32'h0);
    // warm-up shorter than the sample period gates the power
    wr(`ACQS_A_XDCR, 32'h00010002);
    // a calc tick realigns the sample divider before power is judged
    idle(48);
    n = u_acqs_sensor_model.unpowered;
    idle(352);
    rc(`ACQS_A_SPC, 32'h00000002);
    rc(`ACQS_A_CPL, 32'h00000002);
    rd(`ACQS_A_ISTAT, v);
    chk(v & 32'h3, 32'h3);
    chk(u_acqs_sensor_model.a1_cnt, 32'h0);
    chk(rtd_cnt, 32'h0);
    chk(u_acqs_sensor_model.p3_cnt > 0, 32'h1);
    chk(u_acqs_sensor_model.nest_err, 32'h0);
    chk(u_acqs_sensor_model.gap_err, 32'h0);
    chk(u_acqs_sensor_model.unpowered, n);
    chk(u_acqs_sensor_model.off_cycles > 0, 32'h1);
    // warm-up longer than the period keeps power on; bad warm refused
    wr(`ACQS_A_XDCR, 32'h00010006);
    wr(`ACQS_A_XDCR, 32'h00011771);
    rc(`ACQS_A_XDCR, 32'h00010006);
    n = u_acqs_sensor_model.off_cycles;
    idle(200);
    chk(u_acqs_sensor_model.off_cycles, n);
    // transmitters: analog 0 on, 2 warm-up, 3 illegal; pulse 1 and 3
    wr(`ACQS_A_TXC, 32'h000105E1);
    idle(2);
    chk({tx_pulse_power, tx_analog_power}, 32'h55);
    rc(`ACQS_A_PWR, 32'h000000AB);
    wr(`ACQS_A_TXC, 32'h000005E1);
    rc(`ACQS_A_TXC, 32'h00000000);
    chk({tx_pulse_power, tx_analog_power}, 32'h0);
    end_of_test();
  end
endmodule
